// file: dv/rcr_plant_model.sv
`timescale 1ns/100ps
// Regulator stand-in: power good follows enable after a soft start
module rcr_plant_model (
  input  logic       clk_i,
  input  logic       rst_i,
  input  logic [3:0] reg_on_i,
  input  logic [3:0] fault_i,
  output logic [3:0] power_good_o
);
  logic [3:0] ramp1_r;
  logic [3:0] ramp2_r;

  // Two-cycle soft start, one-cycle drop when switched off
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ramp1_r <= 4'h0;
      ramp2_r <= 4'h0;
    end
    else
    begin
      ramp1_r <= reg_on_i;
      ramp2_r <= ramp1_r & reg_on_i;
    end
  end

  // Forced fault pulls the output below threshold
  assign power_good_o = ramp2_r & ~fault_i;
endmodule : rcr_plant_model

// file: dv/rcr_regs_tb.sv
`timescale 1ns/100ps
module rcr_regs_tb;
  logic        clk_i  = 1'b0;
  logic        rst_i  = 1'b1;
  logic        cyc_i  = 1'b0;
  logic        stb_i  = 1'b0;
  logic        we_i   = 1'b0;
  logic [9:0]  adr_i  = 10'h000;
  logic [3:0]  sel_i  = 4'h0;
  logic [31:0] dat_i  = 32'h0000_0000;
  logic        voltage_select_input_r = 1'b0;
  logic [3:0]  fault_r = 4'h0;
  logic        ce_r   = 1'b1;
  logic [31:0] rd_drop;
  logic [31:0] dat_o;
  logic        ack_o;
  logic [3:0]  power_good_i;
  logic [3:0]  reg_on_o;
  logic [1:0]  phase_shift_o;
  logic [5:0]  buck_setpoint_o;
  logic [5:0]  ldo5_code_o;
  logic [5:0]  ldo6_code_o;
  logic [1:0]  bleed_switch_o;
  logic        irq_o;
  int          num_errors = 0;
  int          num_checks = 0;
  logic [7:0]  ctrl_q [4] = '{rcr_pkg::IDX_C3_CTRL, rcr_pkg::IDX_C4_CTRL,
                              rcr_pkg::IDX_C5_CTRL, rcr_pkg::IDX_C6_CTRL};
  logic [7:0]  volt_q [4] = '{rcr_pkg::IDX_C4_VLO, rcr_pkg::IDX_C4_VHI,
                              rcr_pkg::IDX_C5_VOLT, rcr_pkg::IDX_C6_VOLT};

  // 100 MHz clock
  always #5 clk_i = ~clk_i;

  rcr_regs i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_r), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .power_good_i(power_good_i),
    .voltage_select_input_i(voltage_select_input_r), .reg_on_o(reg_on_o),
    .phase_shift_o(phase_shift_o), .buck_setpoint_o(buck_setpoint_o),
    .ldo5_code_o(ldo5_code_o), .ldo6_code_o(ldo6_code_o),
    .bleed_switch_o(bleed_switch_o), .irq_o(irq_o));

  rcr_plant_model i_plant (.clk_i(clk_i), .rst_i(rst_i),
    .reg_on_i(reg_on_o), .fault_i(fault_r), .power_good_o(power_good_i));

  // Shared mismatch bookkeeping
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp

  // One classic Wishbone cycle, held until ack is sampled
  task automatic wb_xfer(input logic wr, input logic [7:0] idx,
                         input logic [7:0] wd, input logic [3:0] sel,
                         output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= wr;
    adr_i <= {idx, 2'b00};
    sel_i <= sel;
    dat_i <= {24'h000000, wd};
    do
    begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      cmp(32'h0, 32'h1, "no ack");
      end_sim();
    end
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
    @(posedge clk_i);
  endtask : wb_xfer

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [31:0] rd;
    wb_xfer(1'b1, idx, wd, 4'hF, rd);
  endtask : wr

  // Register read compare
  task automatic chk_rd(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] rd;
    wb_xfer(1'b0, idx, 8'h00, 4'hF, rd);
    cmp(rd, {24'h000000, exp}, "register read");
  endtask : chk_rd

  // Output pin compare, sampled before the edge updates land
  task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
    cmp({24'h000000, got}, {24'h000000, exp}, "pin");
  endtask : chk_pin

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      chk_rd(ctrl_q[i], 8'h00);
      chk_rd(volt_q[i], 8'h00);
    end
    chk_rd(rcr_pkg::IDX_IRQ_STAT, 8'h00);
    chk_rd(8'h33, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 4; i++)
      wr(ctrl_q[i], 8'hFF);
    repeat (10) @(posedge clk_i);
    for (int i = 0; i < 4; i++)
      chk_rd(ctrl_q[i], 8'h87);
    wb_xfer(1'b1, ctrl_q[0], 8'h00, 4'hE, rd_drop);
    chk_rd(ctrl_q[0], 8'h87);
    chk_pin(8'(reg_on_o), 8'h0F);
    chk_pin(8'(phase_shift_o), 8'h03);
    chk_pin(8'(bleed_switch_o), 8'h00);
    for (int i = 0; i < 4; i++)
      wr(ctrl_q[i], 8'h07);
    repeat (10) @(posedge clk_i);
    for (int i = 0; i < 4; i++)
      chk_rd(ctrl_q[i], 8'h06);
    chk_pin(8'(reg_on_o), 8'h00);
    chk_pin(8'(bleed_switch_o), 8'h03);
    wr(ctrl_q[2], 8'h00);
    wr(ctrl_q[1], 8'h00);
    repeat (3) @(posedge clk_i);
    chk_pin(8'(bleed_switch_o), 8'h02);
    chk_pin(8'(phase_shift_o), 8'h01);
    $display("test control done");
    wr(volt_q[0], 8'hFF);
    wr(volt_q[1], 8'h2A);
    wr(volt_q[2], 8'hD5);
    wr(volt_q[3], 8'h3C);
    chk_rd(volt_q[0], 8'h3F);
    chk_rd(volt_q[2], 8'h15);
    chk_pin(8'(buck_setpoint_o), 8'h3F);
    chk_pin(8'(ldo5_code_o), 8'h15);
    chk_pin(8'(ldo6_code_o), 8'h3C);
    voltage_select_input_r <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk_pin(8'(buck_setpoint_o), 8'h2A);
    voltage_select_input_r <= 1'b0;
    repeat (5) @(posedge clk_i);
    chk_pin(8'(buck_setpoint_o), 8'h3F);
    // Clock enable low freezes the select path
    ce_r   <= 1'b0;
    voltage_select_input_r <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk_pin(8'(buck_setpoint_o), 8'h3F);
    ce_r <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk_pin(8'(buck_setpoint_o), 8'h2A);
    voltage_select_input_r <= 1'b0;
    repeat (5) @(posedge clk_i);
    $display("test voltage done");
    wr(rcr_pkg::IDX_IRQ_EN, 8'h0F);
    chk_rd(rcr_pkg::IDX_IRQ_EN, 8'h0F);
    wr(ctrl_q[2], 8'h82);
    wr(ctrl_q[3], 8'h80);
    repeat (10) @(posedge clk_i);
    fault_r <= 4'h4;
    repeat (10) @(posedge clk_i);
    chk_pin(8'(irq_o), 8'h01);
    chk_rd(rcr_pkg::IDX_IRQ_STAT, 8'h04);
    fault_r <= 4'h0;
    wr(rcr_pkg::IDX_IRQ_CLR, 8'h04);
    repeat (3) @(posedge clk_i);
    chk_pin(8'(irq_o), 8'h00);
    chk_rd(rcr_pkg::IDX_IRQ_CLR, 8'h00);
    fault_r <= 4'h8;
    repeat (10) @(posedge clk_i);
    chk_rd(rcr_pkg::IDX_IRQ_STAT, 8'h00);
    fault_r <= 4'h0;
    wr(rcr_pkg::IDX_IRQ_EN, 8'h00);
    fault_r <= 4'h4;
    repeat (10) @(posedge clk_i);
    chk_rd(rcr_pkg::IDX_IRQ_STAT, 8'h04);
    chk_pin(8'(irq_o), 8'h00);
    wr(rcr_pkg::IDX_IRQ_EN, 8'h04);
    repeat (3) @(posedge clk_i);
    chk_pin(8'(irq_o), 8'h01);
    fault_r <= 4'h0;
    wr(rcr_pkg::IDX_IRQ_CLR, 8'h04);
    wr(ctrl_q[2], 8'h02);
    repeat (10) @(posedge clk_i);
    chk_rd(rcr_pkg::IDX_IRQ_STAT, 8'h00);
    chk_pin(8'(irq_o), 8'h00);
    $display("test fault done");
    end_sim();
  end

  // Watchdog well beyond the expected run length
  initial
  begin
    repeat (20000) @(posedge clk_i);
    cmp(32'h0, 32'h1, "watchdog");
    end_sim();
  end
endmodule : rcr_regs_tb

// file: hw/rcr_chan.sv
`timescale 1ns/100ps
// Power-good synchroniser and fault event detector for one channel
module rcr_chan (
  input  logic clk_i,
  input  logic rst_i,
  input  logic ce_i,
  input  logic power_good_i,
  rcr_chan_if.chan ch
);

  logic pg_meta_r;
  logic pg_sync_r;
  logic pg_prev_r;
  logic fault_r;

  // Two-stage synchroniser on the analog comparator level
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pg_meta_r <= 1'b0;
      pg_sync_r <= 1'b0;
    end
    else if (ce_i)
    begin
      pg_meta_r <= power_good_i;
      pg_sync_r <= pg_meta_r;
    end
  end

  // Falling power-good while on and allowed raises one fault pulse
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pg_prev_r <= 1'b0;
      fault_r   <= 1'b0;
    end
    else if (ce_i)
    begin
      pg_prev_r <= pg_sync_r;
      fault_r   <= pg_prev_r & ~pg_sync_r & ch.on & ch.irq_en;
    end
  end

  assign ch.pg    = pg_sync_r;
  assign ch.fault = fault_r;

  // Fault pulse only after a real drop with the gate open
  chk_fault_cause: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(fault_r) |-> $past(pg_prev_r && !pg_sync_r && ch.on && ch.irq_en))
    else $error("fault pulse without enabled power-good drop");

endmodule : rcr_chan

// file: hw/rcr_chan_if.sv
`timescale 1ns/100ps
// Per-channel link between the register file and a channel monitor
interface rcr_chan_if;
  logic on;
  logic irq_en;
  logic pg;
  logic fault;

  modport regs (output on, output irq_en, input pg, input fault);
  modport chan (input on, input irq_en, output pg, output fault);
endinterface : rcr_chan_if

// file: hw/rcr_pkg.sv
package rcr_pkg;
  // Channel slots: two buck channels then two LDO channels
  localparam int NCH       = 4;
  localparam int CH_THREE  = 0;
  localparam int CH_FOUR   = 1;
  localparam int CH_FIVE   = 2;
  localparam int CH_SIX    = 3;

  // Bus geometry: byte address is four times the register index
  localparam int ADR_W     = 10;
  localparam int IDX_LSB   = 2;
  localparam int IDX_MSB   = 9;

  // Register indices
  localparam logic [7:0] IDX_C3_CTRL  = 8'h32;
  localparam logic [7:0] IDX_C4_VLO   = 8'h40;
  localparam logic [7:0] IDX_C4_VHI   = 8'h41;
  localparam logic [7:0] IDX_C4_CTRL  = 8'h42;
  localparam logic [7:0] IDX_C5_VOLT  = 8'h50;
  localparam logic [7:0] IDX_C5_CTRL  = 8'h51;
  localparam logic [7:0] IDX_C6_VOLT  = 8'h58;
  localparam logic [7:0] IDX_C6_CTRL  = 8'h59;
  localparam logic [7:0] IDX_IRQ_STAT = 8'hA0;
  localparam logic [7:0] IDX_IRQ_CLR  = 8'hA1;
  localparam logic [7:0] IDX_IRQ_EN   = 8'hA2;

  // Control register fields
  localparam int BIT_ON    = 7;
  localparam int BIT_OPT   = 2;
  localparam int BIT_FIE   = 1;
  localparam int BIT_PG    = 0;

  // Voltage code width and reset values
  localparam int VCODE_W   = 6;
  localparam logic [5:0]  VCODE_RST = 6'h00;
  localparam logic [3:0]  CH_RST    = 4'h0;
  localparam logic [1:0]  PAIR_RST  = 2'h0;
  localparam logic [31:0] RD_ZERO   = 32'h0000_0000;
endpackage : rcr_pkg

// file: hw/rcr_regs.sv
`timescale 1ns/100ps
// Behaviour
// - Control bit 7 turns the regulator on or off and reads back.
// - Buck control bit 2 picks 180 degree or aligned switching phase.
// - Control bit 1 enables fault interrupts; cleared, no fault is raised.
// - Control bit 0 reads power-good; writes to it are ignored.
// - Dual buck uses primary code while voltage select is low.
// - Dual buck uses secondary code while voltage select is high.
// - Each LDO has one six-bit voltage code setting its output.
// - LDO bit 2 allows discharge while off; zero never discharges.
module rcr_regs (
  input  logic        clk_i,
  input  logic        rst_i,
  input  logic        ce_i,
  input  logic        cyc_i,
  input  logic        stb_i,
  input  logic        we_i,
  input  logic [9:0]  adr_i,
  input  logic [3:0]  sel_i,
  input  logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic        ack_o,
  input  logic [3:0]  power_good_i,
  input  logic        voltage_select_input_i,
  output logic [3:0]  reg_on_o,
  output logic [1:0]  phase_shift_o,
  output logic [5:0]  buck_setpoint_o,
  output logic [5:0]  ldo5_code_o,
  output logic [5:0]  ldo6_code_o,
  output logic [1:0]  bleed_switch_o,
  output logic        irq_o
);

  logic [3:0]  on_r;
  logic [3:0]  fie_r;
  logic [1:0]  phase_r;
  logic [1:0]  bleed_en_r;
  logic [5:0]  pri_code_r;
  logic [5:0]  sec_code_r;
  logic [5:0]  ldo5_code_r;
  logic [5:0]  ldo6_code_r;
  logic [3:0]  irq_stat_r;
  logic [3:0]  irq_en_r;
  logic        voltage_select_input_meta_r;
  logic        voltage_select_input_sync_r;
  logic [5:0]  setpoint_r;
  logic [1:0]  bleed_r;
  logic        irq_r;
  logic        ack_r;
  logic [31:0] dat_r;
  logic [3:0]  ch_pg;
  logic [3:0]  ch_fault;
  logic [7:0]  idx;
  logic        wr_go;
  logic [31:0] rdata;

  // Register index and write strobe at the acknowledging edge
  assign idx   = adr_i[rcr_pkg::IDX_MSB:rcr_pkg::IDX_LSB];
  assign wr_go = ce_i & cyc_i & stb_i & we_i & ack_r & sel_i[0];

  // Channel monitors, one per channel
  genvar g;
  generate
    for (g = 0; g < rcr_pkg::NCH; g++)
    begin : g_ch
      rcr_chan_if u_if ();
      assign u_if.on     = on_r[g];
      assign u_if.irq_en = fie_r[g];
      assign ch_pg[g]    = u_if.pg;
      assign ch_fault[g] = u_if.fault;
      rcr_chan u_chan (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .ce_i         (ce_i),
        .power_good_i (power_good_i[g]),
        .ch           (u_if)
      );
    end
  endgenerate

  // Control byte assembly; reserved bits stay zero
  function automatic logic [31:0] ctrl_rd(input logic on, input logic opt,
                                          input logic fie, input logic pg);
    logic [31:0] b;
    b = rcr_pkg::RD_ZERO;
    b[rcr_pkg::BIT_ON]  = on;
    b[rcr_pkg::BIT_OPT] = opt;
    b[rcr_pkg::BIT_FIE] = fie;
    b[rcr_pkg::BIT_PG]  = pg;
    return b;
  endfunction : ctrl_rd

  // Read multiplexer; unmapped indices read zero
  always_comb
  begin
    rdata = rcr_pkg::RD_ZERO;
    case (idx)
      rcr_pkg::IDX_C3_CTRL:
        rdata = ctrl_rd(on_r[rcr_pkg::CH_THREE], phase_r[0],
                        fie_r[rcr_pkg::CH_THREE], ch_pg[rcr_pkg::CH_THREE]);
      rcr_pkg::IDX_C4_CTRL:
        rdata = ctrl_rd(on_r[rcr_pkg::CH_FOUR], phase_r[1],
                        fie_r[rcr_pkg::CH_FOUR], ch_pg[rcr_pkg::CH_FOUR]);
      rcr_pkg::IDX_C5_CTRL:
        rdata = ctrl_rd(on_r[rcr_pkg::CH_FIVE], bleed_en_r[0],
                        fie_r[rcr_pkg::CH_FIVE], ch_pg[rcr_pkg::CH_FIVE]);
      rcr_pkg::IDX_C6_CTRL:
        rdata = ctrl_rd(on_r[rcr_pkg::CH_SIX], bleed_en_r[1],
                        fie_r[rcr_pkg::CH_SIX], ch_pg[rcr_pkg::CH_SIX]);
      rcr_pkg::IDX_C4_VLO:   rdata[5:0] = pri_code_r;
      rcr_pkg::IDX_C4_VHI:   rdata[5:0] = sec_code_r;
      rcr_pkg::IDX_C5_VOLT:  rdata[5:0] = ldo5_code_r;
      rcr_pkg::IDX_C6_VOLT:  rdata[5:0] = ldo6_code_r;
      rcr_pkg::IDX_IRQ_STAT: rdata[3:0] = irq_stat_r;
      rcr_pkg::IDX_IRQ_EN:   rdata[3:0] = irq_en_r;
      default:               rdata = rcr_pkg::RD_ZERO;
    endcase
  end

  // Bus answer: ack one cycle after the request, then drop
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r <= 1'b0;
      dat_r <= rcr_pkg::RD_ZERO;
    end
    else if (ce_i)
    begin
      ack_r <= cyc_i & stb_i & ~ack_r;
      if (cyc_i & stb_i & ~ack_r)
        dat_r <= rdata;
    end
  end

  // Control fields; bits 0 and 6:3 are never stored
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      on_r       <= rcr_pkg::CH_RST;
      fie_r      <= rcr_pkg::CH_RST;
      phase_r    <= rcr_pkg::PAIR_RST;
      bleed_en_r <= rcr_pkg::PAIR_RST;
    end
    else if (wr_go)
    begin
      case (idx)
        rcr_pkg::IDX_C3_CTRL:
        begin
          on_r[rcr_pkg::CH_THREE]  <= dat_i[rcr_pkg::BIT_ON];
          phase_r[0]               <= dat_i[rcr_pkg::BIT_OPT];
          fie_r[rcr_pkg::CH_THREE] <= dat_i[rcr_pkg::BIT_FIE];
        end
        rcr_pkg::IDX_C4_CTRL:
        begin
          on_r[rcr_pkg::CH_FOUR]  <= dat_i[rcr_pkg::BIT_ON];
          phase_r[1]              <= dat_i[rcr_pkg::BIT_OPT];
          fie_r[rcr_pkg::CH_FOUR] <= dat_i[rcr_pkg::BIT_FIE];
        end
        rcr_pkg::IDX_C5_CTRL:
        begin
          on_r[rcr_pkg::CH_FIVE]  <= dat_i[rcr_pkg::BIT_ON];
          bleed_en_r[0]           <= dat_i[rcr_pkg::BIT_OPT];
          fie_r[rcr_pkg::CH_FIVE] <= dat_i[rcr_pkg::BIT_FIE];
        end
        rcr_pkg::IDX_C6_CTRL:
        begin
          on_r[rcr_pkg::CH_SIX]  <= dat_i[rcr_pkg::BIT_ON];
          bleed_en_r[1]          <= dat_i[rcr_pkg::BIT_OPT];
          fie_r[rcr_pkg::CH_SIX] <= dat_i[rcr_pkg::BIT_FIE];
        end
        default: ;
      endcase
    end
  end

  // Voltage codes; bits 7:6 are dropped
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pri_code_r  <= rcr_pkg::VCODE_RST;
      sec_code_r  <= rcr_pkg::VCODE_RST;
      ldo5_code_r <= rcr_pkg::VCODE_RST;
      ldo6_code_r <= rcr_pkg::VCODE_RST;
    end
    else if (wr_go)
    begin
      case (idx)
        rcr_pkg::IDX_C4_VLO:  pri_code_r  <= dat_i[5:0];
        rcr_pkg::IDX_C4_VHI:  sec_code_r  <= dat_i[5:0];
        rcr_pkg::IDX_C5_VOLT: ldo5_code_r <= dat_i[5:0];
        rcr_pkg::IDX_C6_VOLT: ldo6_code_r <= dat_i[5:0];
        default: ;
      endcase
    end
  end

  // Sticky fault status; a new event wins over a clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_stat_r <= rcr_pkg::CH_RST;
    else if (ce_i)
    begin
      if (wr_go && idx == rcr_pkg::IDX_IRQ_CLR)
        irq_stat_r <= (irq_stat_r & ~dat_i[3:0]) | ch_fault;
      else
        irq_stat_r <= irq_stat_r | ch_fault;
    end
  end

  // Interrupt enable register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_en_r <= rcr_pkg::CH_RST;
    else if (wr_go && idx == rcr_pkg::IDX_IRQ_EN)
      irq_en_r <= dat_i[3:0];
  end

  // Voltage select synchroniser, then the setpoint multiplexer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      voltage_select_input_meta_r <= 1'b0;
      voltage_select_input_sync_r <= 1'b0;
      setpoint_r  <= rcr_pkg::VCODE_RST;
    end
    else if (ce_i)
    begin
      voltage_select_input_meta_r <= voltage_select_input_i;
      voltage_select_input_sync_r <= voltage_select_input_meta_r;
      setpoint_r  <= voltage_select_input_sync_r ? sec_code_r : pri_code_r;
    end
  end

  // Discharge switches and interrupt line
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bleed_r <= rcr_pkg::PAIR_RST;
      irq_r   <= 1'b0;
    end
    else if (ce_i)
    begin
      bleed_r <= bleed_en_r & ~on_r[rcr_pkg::CH_SIX:rcr_pkg::CH_FIVE];
      irq_r   <= |(irq_stat_r & irq_en_r);
    end
  end

  assign dat_o           = dat_r;
  assign ack_o           = ack_r;
  assign reg_on_o        = on_r;
  assign phase_shift_o   = phase_r;
  assign buck_setpoint_o = setpoint_r;
  assign ldo5_code_o     = ldo5_code_r;
  assign ldo6_code_o     = ldo6_code_r;
  assign bleed_switch_o  = bleed_r;
  assign irq_o           = irq_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

  chk_enable_write: assert property (
    wr_go && idx == rcr_pkg::IDX_C4_CTRL
      |=> reg_on_o[rcr_pkg::CH_FOUR] == $past(dat_i[rcr_pkg::BIT_ON]))
    else $error("enable bit not taken from write");

  chk_phase_write: assert property (
    wr_go && idx == rcr_pkg::IDX_C3_CTRL
      |=> phase_shift_o[0] == $past(dat_i[rcr_pkg::BIT_OPT]))
    else $error("phase bit not taken from write");

  chk_fault_gate: assert property (
    $rose(irq_stat_r[rcr_pkg::CH_FIVE]) |-> $past(fie_r[rcr_pkg::CH_FIVE], 2))
    else $error("fault status set with interrupt disabled");

  chk_pg_readback: assert property (
    ack_o && !we_i && $past(idx) == rcr_pkg::IDX_C3_CTRL && $past(ce_i)
      |-> dat_o[rcr_pkg::BIT_PG] == $past(ch_pg[rcr_pkg::CH_THREE]))
    else $error("power-good readback wrong");

  chk_setpoint_low: assert property (
    ce_i && !voltage_select_input_sync_r |=> buck_setpoint_o == $past(pri_code_r))
    else $error("primary code not driven while select low");

  chk_setpoint_high: assert property (
    ce_i && voltage_select_input_sync_r |=> buck_setpoint_o == $past(sec_code_r))
    else $error("secondary code not driven while select high");

  chk_ldo_code: assert property (
    wr_go && idx == rcr_pkg::IDX_C6_VOLT ##1 !wr_go
      |-> ldo6_code_o == $past(dat_i[5:0], 1) || $past(ce_i) == 1'b0)
    else $error("ldo code not taken from write");

  chk_bleed_cause: assert property (
    $past(ce_i) && bleed_switch_o[1]
      |-> $past(bleed_en_r[1] && !on_r[rcr_pkg::CH_SIX]))
    else $error("discharge asserted without cause");

  chk_reserved_zero: assert property (
    ack_o && !we_i && $past(idx) == rcr_pkg::IDX_C4_VLO && $past(ce_i)
      |-> dat_o[31:6] == 26'h0)
    else $error("reserved voltage bits not zero");

  cov_write: cover property (wr_go && idx == rcr_pkg::IDX_C4_VHI);
  cov_irq: cover property ($rose(irq_o));
  cov_bleed: cover property ($rose(bleed_switch_o[0]));
  cov_voltage_select_input: cover property ($rose(voltage_select_input_sync_r));

endmodule : rcr_regs
